// *** rtl/motor_run_ctrl.sv ***
// Run, brake, direction and restart control of the motor driver
`timescale 1ns/1ns
`include "motor_run_params.svh"
module motor_run_ctrl
  import motor_run_pkg::*;
(
  input  wire logic             ref_clk,      // 125 MHz clock
  input  wire logic             rst_n,        // Async reset, active low
  input  wire logic             wr_en,        // Register write strobe
  input  wire logic [4:0]       wr_addr,      // Register number to write
  input  wire logic [15:0]      wr_data,      // Write word
  input  wire logic             rd_en,        // Register read strobe
  input  wire logic [4:0]       rd_addr,      // Register number to read
  input  wire logic             dir_pin,      // Direction pin level
  input  wire trip_events_t     trips,        // Detected trip events
  input  wire fault_flags_t     faults,       // Live critical fault flags
  output logic [15:0]           rd_data,      // Read word
  output logic                  rd_valid,     // Read data valid pulse
  output bridge_ctrl_t [2:0]    bridge,       // Per-phase switch enables
  output logic                  excite,       // Excitation active
  output logic                  dir_reverse,  // Effective direction reverse
  output logic                  braking,      // Braking active
  output logic                  restarting    // Restart in progress
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [`SETTING_W-1:0] run_ctrl;
  logic [`SETTING_W-1:0] next_run_ctrl;
  logic [`SETTING_W-1:0] settings [`REG_COUNT];
  logic [`SETTING_W-1:0] next_settings [`REG_COUNT];
  logic [15:0]           rd_word;

  always_comb begin
    next_run_ctrl = run_ctrl;
    next_settings = settings;
    if (wr_en) begin
      // Only the low field is stored; fault bits are status only
      if (wr_addr == `RUN_CTRL_REG) begin
        next_run_ctrl = wr_data[`SETTING_W-1:0];
      end else begin
        next_settings[wr_addr] = wr_data[`SETTING_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ctrl <= `RUN_CTRL_RESET;
      for (int i = 0; i < `REG_COUNT; i++) begin
        settings[i] <= `RUN_CTRL_RESET;
      end
    end else begin
      run_ctrl <= next_run_ctrl;
      settings <= next_settings;
    end
  end

  reg_readback u_readback (
    .rd_addr        (rd_addr),
    .run_ctrl       (run_ctrl),
    .other_settings (settings),
    .faults         (faults),
    .rd_data        (rd_word)
  );

  logic [15:0] next_rd_data;
  logic        next_rd_valid;

  always_comb begin
    next_rd_data  = rd_en ? rd_word : rd_data;
    next_rd_valid = rd_en;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------
  logic run_bit;
  logic brake_request;
  logic restart_select;
  logic any_trip;

  assign run_bit        = run_ctrl[`RUN_BIT];
  assign brake_request  = run_ctrl[`BRAKE_BIT];
  assign restart_select = run_ctrl[`RESTART_SEL_BIT];
  assign any_trip       = trips.sync_lost | trips.soft_overcurrent_trip
                        | trips.hard_overcurrent_trip;

  run_state_t  state;
  run_state_t  next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic        restart_pend;
  logic        next_restart_pend;

  always_comb begin
    next_state        = state;
    next_timer        = (timer != 16'h0000) ? timer - 16'h0001 : timer;
    next_restart_pend = restart_pend;
    case (state)
      st_idle: begin
        if (run_bit) begin
          next_state = st_startup;
          next_timer = 16'(`STARTUP_BRAKE_CYC);
        end
      end
      st_startup: begin
        // Alignment braking ignores the brake bit
        if (!run_bit) begin
          next_state = st_idle;
        end else if (timer == 16'h0000) begin
          next_state        = st_drive;
          next_restart_pend = 1'b0;
        end
      end
      st_drive: begin
        if (!run_bit) begin
          next_state = st_idle;
        end else if (brake_request) begin
          next_state = st_brake;
        end else if (any_trip) begin
          next_state = st_coast;
          // Sync loss without restart select coasts for good
          if (restart_select) begin
            next_restart_pend = 1'b1;
            next_timer        = 16'(`RESTART_DELAY_CYC);
          end else begin
            next_restart_pend = 1'b0;
          end
        end
      end
      st_brake: begin
        if (!run_bit) begin
          next_state = st_idle;
        end else if (!brake_request) begin
          next_state = st_drive;
        end
      end
      st_coast: begin
        if (!run_bit) begin
          next_state        = st_idle;
          next_restart_pend = 1'b0;
        end else if (restart_pend && restart_select && !brake_request
                     && timer == 16'h0000) begin
          next_state = st_startup;
          next_timer = 16'(`STARTUP_BRAKE_CYC);
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= st_idle;
      timer        <= 16'h0000;
      restart_pend <= 1'b0;
    end else begin
      state        <= next_state;
      timer        <= next_timer;
      restart_pend <= next_restart_pend;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  bridge_ctrl_t [2:0] next_bridge;
  logic               next_excite;
  logic               next_dir_reverse;
  logic               next_braking;
  logic               next_restarting;

  always_comb begin
    next_excite      = (next_state == st_drive);
    next_braking     = (next_state == st_brake)
                     || (next_state == st_startup);
    next_dir_reverse = run_ctrl[`DIR_BIT] ^ dir_pin;
    next_restarting  = next_restart_pend;
    for (int p = 0; p < 3; p++) begin
      next_bridge[p].high_on = 1'b0;
      next_bridge[p].low_on  = next_braking;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bridge      <= '0;
      excite      <= 1'b0;
      dir_reverse <= 1'b0;
      braking     <= 1'b0;
      restarting  <= 1'b0;
    end else begin
      bridge      <= next_bridge;
      excite      <= next_excite;
      dir_reverse <= next_dir_reverse;
      braking     <= next_braking;
      restarting  <= next_restarting;
    end
  end

endmodule // motor_run_ctrl

// *** rtl/motor_run_params.svh ***
// Offsets, field positions, reset values and timing counts for run control
`ifndef MOTOR_RUN_PARAMS_SVH
`define MOTOR_RUN_PARAMS_SVH

`define RUN_CTRL_REG        5'h1f
`define RUN_BIT             0
`define DIR_BIT             1
`define BRAKE_BIT           2
`define RESTART_SEL_BIT     3
`define SETTING_W           10
`define FAULT_LSB           10
`define RUN_CTRL_RESET      10'h000
`define REG_COUNT           32
`define RESTART_DELAY_NS    1000
`define CLK_PERIOD_NS       8
`define RESTART_DELAY_CYC   ((`RESTART_DELAY_NS) / (`CLK_PERIOD_NS))
`define STARTUP_BRAKE_NS    800
`define STARTUP_BRAKE_CYC   ((`STARTUP_BRAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/motor_run_pkg.sv ***
// Types shared by the run control logic
package motor_run_pkg;

  typedef struct packed {
    logic general_fault_flag;
    logic logic_undervoltage_flag;
    logic memory_error_flag;
    logic watchdog_expired_flag;
    logic soft_overcurrent_flag;
    logic nv_write_limit_flag;
  } fault_flags_t;

  typedef struct packed {
    logic sync_lost;
    logic soft_overcurrent_trip;
    logic hard_overcurrent_trip;
  } trip_events_t;

  typedef struct packed {
    logic high_on;
    logic low_on;
  } bridge_ctrl_t;

  typedef enum logic [4:0] {
    st_idle    = 5'b00001,
    st_startup = 5'b00010,
    st_drive   = 5'b00100,
    st_brake   = 5'b01000,
    st_coast   = 5'b10000
  } run_state_t;

endpackage

// *** rtl/reg_readback.sv ***
// Register read mux that places the shared fault field above each setting
`timescale 1ns/1ns
`include "motor_run_params.svh"
module reg_readback
  import motor_run_pkg::*;
(
  input  wire logic [4:0]                rd_addr,  // Register number
  input  wire logic [`SETTING_W-1:0]     run_ctrl, // Run control settings
  input  wire logic [`SETTING_W-1:0]     other_settings [`REG_COUNT], // Rest
  input  wire fault_flags_t              faults,   // Live fault flags
  output logic [15:0]                    rd_data   // Composed read word
);
  always_comb begin
    if (rd_addr == `RUN_CTRL_REG) begin
      rd_data = {faults, run_ctrl};
    end else begin
      rd_data = {faults, other_settings[rd_addr]};
    end
  end
endmodule // reg_readback

// *** testbench/motor_far_side.sv ***
// Host pin discipline and motor trip events
`timescale 1ns/1ns
module motor_far_side
  import motor_run_pkg::*;
(
  input  wire logic         ref_clk,   // Clock
  input  wire logic         supply_up, // Logic supply established
  input  wire logic         dir_want,  // Wanted direction level
  input  wire logic         speed_command_voltage, // Speed command level
  input  wire logic         excite,    // Motor excited
  input  wire trip_events_t trip_req,  // Trip to report
  output logic              dir_pin,   // Direction pin
  output trip_events_t      trips      // Trip events
);
  logic spinning = 1'b0;
  assign dir_pin = supply_up & dir_want;
  // A motor at rest cannot lose sync or overcurrent; the host drops the
  // speed command before clearing run, so the rotor winds down first
  always @(negedge ref_clk) spinning <= excite & speed_command_voltage;
  assign trips = spinning ? trip_req : '0;
endmodule // motor_far_side

// *** testbench/motor_run_ctrl_asserts.sv ***
// Checker for the run control block ports
`timescale 1ns/1ns
module motor_run_ctrl_asserts
  import motor_run_pkg::*;
(
  input wire logic               ref_clk,     // Clock
  input wire logic               rst_n,       // Reset
  input wire logic               wr_en,       // Write
  input wire logic [4:0]         wr_addr,     // Write register
  input wire logic [15:0]        wr_data,     // Write word
  input wire logic               rd_en,       // Read
  input wire logic [4:0]         rd_addr,     // Read register
  input wire logic               dir_pin,     // Direction pin
  input wire trip_events_t       trips,       // Trips
  input wire fault_flags_t       faults,      // Faults
  input wire logic [15:0]        rd_data,     // Read word
  input wire logic               rd_valid,    // Read valid
  input wire bridge_ctrl_t [2:0] bridge,      // Switches
  input wire logic               excite,      // Excitation
  input wire logic               dir_reverse, // Direction
  input wire logic               braking,     // Braking
  input wire logic               restarting   // Restart
);
  logic [3:0] rc;
  logic [3:0] next_rc;
  // Mirror of the low run control bits as last written
  always_comb next_rc = (wr_en && wr_addr == 5'h1f) ? wr_data[3:0] : rc;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) rc <= 4'h0;
    else rc <= next_rc;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_fault_field: assert property (rd_en |=> rd_valid &&
    rd_data[15:10] == $past(faults)) else $error("fault field wrong");
  a_run_bits_read: assert property (rd_en && rd_addr == 5'h1f |=>
    rd_data[3:0] == $past(rc)) else $error("run bits read wrong");
  a_dir_combine: assert property ((!wr_en && $stable(dir_pin))[*3] |->
    dir_reverse == (rc[1] ^ dir_pin)) else $error("direction wrong");
  a_stop_idle: assert property ((!rc[0])[*3] |->
    !excite && !braking && bridge == '0) else $error("not stopped");
  a_start_brake: assert property ($rose(rc[0]) |=> braking)
    else $error("no startup braking");
  a_low_sides: assert property (braking |-> bridge == 6'h15)
    else $error("low sides not all on");
  a_run_brake: assert property (excite && rc[0] && rc[2] |=>
    braking && bridge == 6'h15) else $error("drive did not brake");
  a_no_restart: assert property (excite && !rc[3] && !rc[2] &&
    trips.sync_lost |-> ##2 (!excite && !restarting)[*3])
    else $error("no coast on sync loss");
  a_restart_trip: assert property (excite && rc[0] && rc[3] &&
    !rc[2] && |trips |-> ##[1:2] restarting ##[120:130] braking)
    else $error("no restart");
  cover property (restarting);
  cover property (braking && rc[2] && rc[0]);
  cover property (rd_en && rd_addr == 5'h1f);
endmodule // motor_run_ctrl_asserts

bind motor_run_ctrl motor_run_ctrl_asserts chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .rd_en(rd_en), .rd_addr(rd_addr), .dir_pin(dir_pin), .trips(trips),
  .faults(faults), .rd_data(rd_data), .rd_valid(rd_valid),
  .bridge(bridge), .excite(excite), .dir_reverse(dir_reverse),
  .braking(braking), .restarting(restarting));

// *** testbench/tb_motor_run_ctrl.sv ***
// Self-checking bench for the run control block
`timescale 1ns/1ns
module tb_motor_run_ctrl
  import motor_run_pkg::*;
;
  typedef struct packed {
    logic [4:0]  a;
    logic [15:0] w;
    logic [5:0]  f;
    logic [15:0] x;
  } row_t;
  row_t rows [4] = '{'{5'h00, 16'hffff, 6'h2a, 16'habff},
    '{5'h1e, 16'h0155, 6'h15, 16'h5555},
    '{5'h1f, 16'hfff0, 6'h3f, 16'hfff0},
    '{5'h07, 16'h0000, 6'h20, 16'h8000}};
  logic ref_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0;
  logic supply_up = 0, dir_want = 0, dir_pin;
  logic speed_command_voltage = 1;
  logic [4:0] wr_addr = 0, rd_addr = 0;
  logic [15:0] wr_data = 0, rd_data;
  fault_flags_t faults = '0;
  trip_events_t trip_req = '0, trips;
  bridge_ctrl_t [2:0] bridge;
  logic rd_valid, excite, dir_reverse, braking, restarting;
  int miscompares = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  motor_run_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .dir_pin(dir_pin), .trips(trips),
    .faults(faults), .rd_data(rd_data), .rd_valid(rd_valid),
    .bridge(bridge), .excite(excite), .dir_reverse(dir_reverse),
    .braking(braking), .restarting(restarting));
  motor_far_side far (.ref_clk(ref_clk), .supply_up(supply_up),
    .speed_command_voltage(speed_command_voltage),
    .dir_want(dir_want), .excite(excite), .trip_req(trip_req),
    .dir_pin(dir_pin), .trips(trips));
  task end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_b(input string n, input logic e, input logic g);
    chk_w(n, {15'h0, e}, {15'h0, g});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    wr_en = 1; wr_addr = a; wr_data = d;
    @(negedge ref_clk);
    wr_en = 0;
  endtask
  task rd(input logic [4:0] a);
    @(negedge ref_clk);
    rd_en = 1; rd_addr = a;
    @(negedge ref_clk);
    rd_en = 0;
    chk_b("rd_valid", 1'b1, rd_valid);
  endtask
  // Bounded wait for the excitation level
  task wait_ex(input logic v);
    int i;
    for (i = 0; i < 400 && excite !== v; i++) @(negedge ref_clk);
    chk_b("excite", v, excite);
    if (excite !== v) end_of_test;
  endtask
  initial begin
    cyc(2);
    supply_up = 1;
    rst_n = 1;
    chk_w("bridge", 16'h0, {10'h0, bridge});
    rd(5'h1f);
    chk_w("reset value", 16'h0000, rd_data);
    foreach (rows[i]) begin
      faults = rows[i].f;
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk_w("rd_data", rows[i].x, rd_data);
    end
    faults = '0;
    for (int k = 0; k < 4; k++) begin
      dir_want = k[0];
      wr(5'h1f, {14'h0, k[1], 1'b0});
      cyc(3);
      chk_b("dir_reverse", k[0] ^ k[1], dir_reverse);
    end
    wr(5'h1f, 16'h0001);
    cyc(2);
    chk_w("startup bridge", 16'h0015, {10'h0, bridge});
    wait_ex(1);
    wr(5'h1f, 16'h0005);
    cyc(3);
    chk_w("brake bridge", 16'h0015, {10'h0, bridge});
    wr(5'h1f, 16'h0004);
    cyc(3);
    chk_b("braking", 1'b0, braking);
    // Three trip kinds with restart allowed, then sync loss without
    for (int t = 0; t < 4; t++) begin
      wr(5'h1f, (t < 3) ? 16'h0009 : 16'h0001);
      wait_ex(1);
      trip_req = 3'b100 >> (t % 3);
      cyc(1);
      trip_req = '0;
      cyc(3);
      chk_b("restarting", t < 3, restarting);
      if (t < 3) wait_ex(1);
      else cyc(300);
      chk_b("excite after trip", t < 3, excite);
    end
    // Supply dip while driving: host pulls reset and pins low again
    wr(5'h1f, 16'h0000);
    wr(5'h1f, 16'h0001);
    wait_ex(1);
    supply_up = 0;
    rst_n = 0;
    cyc(2);
    chk_b("excite in reset", 1'b0, excite);
    chk_b("dir_reverse in reset", 1'b0, dir_reverse);
    chk_w("rd_data in reset", 16'h0000, rd_data);
    supply_up = 1;
    rst_n = 1;
    rd(5'h1f);
    chk_w("run after reset", 16'h0000, rd_data);
    // Orderly stop: speed command first, then the run bit
    wr(5'h1f, 16'h0001);
    wait_ex(1);
    speed_command_voltage = 0;
    cyc(2);
    wr(5'h1f, 16'h0000);
    cyc(3);
    chk_b("excite after stop", 1'b0, excite);
    chk_w("bridge after stop", 16'h0000, {10'h0, bridge});
    end_of_test;
  end
endmodule // tb_motor_run_ctrl
